// File: rtl/shift_pair_pkg.sv
`default_nettype none

// Shared constants for the two-rank register and its bus slave.
package shift_pair_pkg;

   // Register width and bus geometry.
   localparam int          WORD_BITS = 8;
   localparam int          ADDR_BITS = 4;
   localparam int          BUS_BITS  = 32;

   // Byte addresses of the software registers.
   localparam logic [3:0]  CTRL_ADDR = 4'h0;
   localparam logic [3:0]  STEP_ADDR = 4'h4;
   localparam logic [3:0]  STAT_ADDR = 4'h8;

   // Control register fields; disable bits are active low.
   localparam int          OUT_DIS_BIT   = 0;
   localparam int          IN_DIS_BIT    = 1;
   localparam int          UP_DIS_BIT    = 2;
   localparam int          DOWN_DIS_BIT  = 3;
   localparam int          SHIFT_DIS_BIT = 4;
   localparam int          RUN_BIT       = 5;
   localparam int          CTRL_BITS     = 6;
   localparam int          MODE_BITS     = 5;
   localparam logic [5:0]  CTRL_RESET    = 6'h3F;

   // Status register fields.
   localparam int          STAT_A_LSB    = 0;
   localparam int          STAT_B_LSB    = 8;
   localparam int          STAT_SOUT_BIT = 16;
   localparam int          STAT_EMPTY    = 17;
   localparam int          STAT_FULL     = 18;

   // Step queue geometry and synchroniser depth.
   localparam int          STEP_DEPTH    = 8;
   localparam int          SYNC_STAGES   = 2;

   typedef logic [WORD_BITS-1:0] word_t;

endpackage

`default_nettype wire

// File: rtl/pin_sync.sv
`default_nettype none

// Two-stage synchroniser for levels arriving from the pins.
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Asynchronous level in, synchronised level out.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second, so a metastable value never
   // reaches any decision logic.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         meta     <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire

// File: rtl/step_fifo.sv
`default_nettype none

// Small synchronous FIFO with valid and ready on both sides.
module step_fifo
#(
   parameter int WIDTH = 5,
   parameter int DEPTH = 8
)
(
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Filling side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // Fill state.
   output logic                  full,
   output logic                  empty
);

   localparam int PTR_BITS = $clog2(DEPTH);

   logic [WIDTH-1:0]    store [DEPTH];
   logic [PTR_BITS-1:0] wr_ptr;
   logic [PTR_BITS-1:0] rd_ptr;
   logic [PTR_BITS:0]   count;
   logic                push;
   logic                pop;

   // Handshakes; full and empty come straight from the occupancy count.
   assign full      = (count == (PTR_BITS+1)'(DEPTH));
   assign empty     = (count == '0);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = store[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage is written without reset; only the pointers and the count need a known value.
   always_ff @(posedge core_clk)
   begin
      if (push)
         store[wr_ptr] <= in_data;
   end

   // Pointers wrap at the depth, which need not be a power of two.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == PTR_BITS'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == PTR_BITS'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (PTR_BITS+1)'(push) - (PTR_BITS+1)'(pop);
      end
   end

endmodule

`default_nettype wire

// File: rtl/dual_rank_bus_shift_register.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`default_nettype none

module dual_rank_bus_shift_register
#(
   parameter int STEP_DEPTH = shift_pair_pkg::STEP_DEPTH
)
(
   // Clock and reset.
   input  wire logic                              core_clk,
   input  wire logic                              rst_n,
   // Avalon-MM register slave.
   input  wire logic [shift_pair_pkg::ADDR_BITS-1:0] address,
   input  wire logic                              read,
   input  wire logic                              write,
   input  wire logic [shift_pair_pkg::BUS_BITS-1:0]  writedata,
   output logic      [shift_pair_pkg::BUS_BITS-1:0]  readdata,
   output logic                                   waitrequest,
   // Shared parallel pins, split into in, out and enable.
   input  wire logic [shift_pair_pkg::WORD_BITS-1:0] io_in,
   output logic      [shift_pair_pkg::WORD_BITS-1:0] io_out,
   output logic                                   io_oe_n,
   // Serial chain pins.
   input  wire logic                              serial_in,
   output logic                                   serial_out
);
   import shift_pair_pkg::*;

   word_t                a_reg;
   word_t                b_reg;
   word_t                pins;
   logic                 serial_bit;
   logic [CTRL_BITS-1:0] ctrl;
   logic                 read_done;
   logic                 sel_ctrl;
   logic                 sel_step;
   logic                 sel_stat;
   logic                 step_push;
   logic                 step_ready;
   logic                 step_valid;
   logic [MODE_BITS-1:0] step_mode;
   logic                 q_full;
   logic                 q_empty;
   logic                 step;
   logic                 up_req;
   logic                 down_req;
   logic                 shift_req;
   logic                 in_en;
   logic                 out_dis;
   logic                 load_ok;
   logic                 drive_pins;
   word_t                next_a;
   word_t                next_b;
   logic [BUS_BITS-1:0]  next_readdata;

   // Pins come from another device, so they pass two flops first.
   // The serial pin rides in the same pair, so both see equal latency.
   pin_sync #(.WIDTH(WORD_BITS + 1)) u_sync
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in ({serial_in, io_in}),
      .sync_out ({serial_bit, pins})
   );

   // Address decode; unmapped words read zero and ignore writes.
   assign sel_ctrl  = (address == CTRL_ADDR);
   assign sel_step  = (address == STEP_ADDR);
   assign sel_stat  = (address == STAT_ADDR);
   assign step_push = write && sel_step;

   // A step write stalls while the queue is full, which pushes back on
   // software instead of dropping a clock edge's worth of work.
   assign waitrequest = (read && !read_done) || (step_push && !step_ready);

   // Control register write and read data capture.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctrl      <= CTRL_RESET;
         read_done <= 1'b0;
         readdata  <= '0;
      end
      else
      begin
         if (write && sel_ctrl)
            ctrl <= writedata[CTRL_BITS-1:0];
         read_done <= read && !read_done;
         if (read && !read_done)
            readdata <= next_readdata;
      end
   end

   // Read multiplexer; status shows both ranks and the queue state.
   always_comb
   begin
      next_readdata = '0;
      if (sel_ctrl)
         next_readdata[CTRL_BITS-1:0] = ctrl;
      else if (sel_stat)
      begin
         next_readdata[STAT_A_LSB +: WORD_BITS] = a_reg;
         next_readdata[STAT_B_LSB +: WORD_BITS] = b_reg;
         next_readdata[STAT_SOUT_BIT]           = serial_out;
         next_readdata[STAT_EMPTY]              = q_empty;
         next_readdata[STAT_FULL]               = q_full;
      end
   end

   // Each queued word is one device clock edge with its mode selects.
   // Clearing the run bit stalls the drain, so software can batch edges.
   step_fifo #(.WIDTH(MODE_BITS), .DEPTH(STEP_DEPTH)) u_queue
   (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (step_push),
      .in_ready  (step_ready),
      .in_data   (ctrl[MODE_BITS-1:0]),
      .out_valid (step_valid),
      .out_ready (ctrl[RUN_BIT]),
      .out_data  (step_mode),
      .full      (q_full),
      .empty     (q_empty)
   );

   // Mode selects of the step now executing, all asserted low.
   assign step      = step_valid && ctrl[RUN_BIT];
   assign up_req    = !step_mode[UP_DIS_BIT];
   assign down_req  = !step_mode[DOWN_DIS_BIT];
   assign shift_req = !step_mode[SHIFT_DIS_BIT];
   assign in_en     = step_mode[IN_DIS_BIT];
   assign out_dis   = !step_mode[OUT_DIS_BIT];
   assign load_ok   = in_en && out_dis;

   // Pins drive A whenever output is enabled, or whenever input is
   // disabled, since input disable dominates the output control.
   assign drive_pins = ctrl[OUT_DIS_BIT] || !ctrl[IN_DIS_BIT];
   assign io_oe_n    = !drive_pins;
   assign io_out     = a_reg;
   assign serial_out = b_reg[WORD_BITS-1];

   // Next value of A: exchange, then transfer up (merged with the pins
   // when they are inputs), then parallel load, else hold.
   always_comb
   begin
      next_a = a_reg;
      if (step)
      begin
         if (up_req && down_req)
            next_a = b_reg;
         else if (up_req && load_ok)
            next_a = pins | b_reg;
         else if (up_req)
            next_a = b_reg;
         else if (load_ok)
            next_a = pins;
      end
   end

   // Next value of B: exchange or transfer down beat a shift; a floating
   // pin bus has no effect on any of them.
   always_comb
   begin
      next_b = b_reg;
      if (step)
      begin
         if (down_req)
            next_b = a_reg;
         else if (shift_req && !up_req)
            next_b = {b_reg[WORD_BITS-2:0], serial_bit};
      end
   end

   // Both ranks update together on the rising edge only.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         a_reg <= '0;
         b_reg <= '0;
      end
      else
      begin
         a_reg <= next_a;
         b_reg <= next_b;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // Each step check compares a rank with values sampled one edge earlier,
   // the pins included, so it holds whatever the pins carry; the pin checks
   // compare outputs in the same cycle. Reset aborts them, since both ranks are cleared then.

   chk_load_pins: assert property (
      step && load_ok && !up_req |=> a_reg == $past(pins))
      else $error("A did not capture the pins on a load.");

   chk_down_copy: assert property (
      step && down_req && !up_req |=> b_reg == $past(a_reg))
      else $error("B did not receive A on transfer down.");

   chk_up_copy: assert property (
      step && up_req && !down_req && !load_ok
      |=> a_reg == $past(b_reg))
      else $error("A did not receive B on transfer up.");

   chk_shift_in: assert property (
      step && shift_req && !up_req && !down_req
      |=> b_reg == {$past(b_reg[WORD_BITS-2:0]), $past(serial_bit)})
      else $error("B did not shift in the serial bit.");

   chk_swap_ranks: assert property (
      step && up_req && down_req
      |=> a_reg == $past(b_reg) && b_reg == $past(a_reg))
      else $error("Exchange did not swap A and B.");

   chk_idle_hold: assert property (
      !step |=> $stable(a_reg) && $stable(b_reg))
      else $error("A rank changed with no step pending.");

   chk_input_dominates: assert property (
      !ctrl[IN_DIS_BIT] |-> !io_oe_n && io_out == a_reg)
      else $error("Input disable did not force the pins to drive.");

   chk_merge_or: assert property (
      step && up_req && !down_req && load_ok
      |=> a_reg == ($past(pins) | $past(b_reg)))
      else $error("Merge did not OR the pins with B.");

   chk_serial_tail: assert property (
      step && shift_req && !up_req && !down_req
      |=> serial_out == $past(b_reg[WORD_BITS-2]))
      else $error("Serial output lost the shifted stage.");

   chk_float_runs: assert property (
      step && io_oe_n && down_req && !up_req
      |=> b_reg == $past(a_reg))
      else $error("Floating pins blocked a transfer.");

   chk_load_keeps_b: assert property (
      step && load_ok && !up_req && !down_req && !shift_req
      |=> $stable(b_reg))
      else $error("A parallel load disturbed B.");

   chk_down_keeps_a: assert property (
      step && down_req && !up_req && !load_ok |=> $stable(a_reg))
      else $error("Transfer down disturbed A.");

   chk_up_keeps_b: assert property (
      step && up_req && !down_req |=> $stable(b_reg))
      else $error("Transfer up disturbed B.");

   chk_shift_keeps_a: assert property (
      step && shift_req && !up_req && !down_req && !load_ok
      |=> $stable(a_reg))
      else $error("A shift disturbed A.");

   chk_output_enable: assert property (
      ctrl[OUT_DIS_BIT] |-> !io_oe_n && io_out == a_reg)
      else $error("Enabled pins did not show A.");

   chk_output_float: assert property (
      !ctrl[OUT_DIS_BIT] && ctrl[IN_DIS_BIT] |-> io_oe_n)
      else $error("Disabled pins were still driven.");

   chk_load_float: assert property (
      step && io_oe_n && load_ok && !up_req |=> a_reg == $past(pins))
      else $error("Floating pins blocked a parallel load.");

   chk_idle_mode: assert property (
      step && !up_req && !down_req && !shift_req && !load_ok
      |=> $stable(a_reg) && $stable(b_reg))
      else $error("A step with no request changed a rank.");

   chk_serial_hold: assert property (
      !step |=> $stable(serial_out))
      else $error("Serial output moved with no step.");

endmodule

`default_nettype wire

// File: bench/pin_bus_model.sv
`default_nettype none

// Far side of the shared pins: other bus drivers and the upstream chain.
module pin_bus_model
   import shift_pair_pkg::*;
(
   // Clock.
   input  wire logic                  core_clk,
   // Device side of the shared pins.
   input  wire shift_pair_pkg::word_t io_out,
   input  wire logic                  io_oe_n,
   output shift_pair_pkg::word_t      io_in,
   // What the other bus driver puts on the pins, and whether it drives.
   input  wire logic                  bus_en,
   input  wire shift_pair_pkg::word_t bus_val,
   // Output of the upstream device in the serial chain.
   input  wire logic                  up_bit,
   output logic                       serial_in
);
   timeunit 1ns;
   timeprecision 1ns;

   word_t last_level = 8'h00;

   // A floating bus flips every cycle, so a stale value never passes.
   assign io_in = !io_oe_n ? io_out
                           : (bus_en ? bus_val : ~last_level);
   assign serial_in = up_bit;

   // Remember the last level seen on the wire.
   always @(posedge core_clk)
   begin
      last_level <= io_in;
   end
endmodule

`default_nettype wire

// File: bench/tb_dual_rank_bus_shift_register.sv
`default_nettype none

module tb_dual_rank_bus_shift_register;
   timeunit 1ns;
   timeprecision 1ns;
   import shift_pair_pkg::*;

   logic                 core_clk = 1'b0;
   logic                 rst_n;
   logic                 read;
   logic                 write;
   logic                 waitrequest;
   logic                 io_oe_n;
   logic                 serial_in;
   logic                 serial_out;
   logic                 bus_en;
   logic                 up_bit;
   logic [ADDR_BITS-1:0] address;
   logic [BUS_BITS-1:0]  writedata;
   logic [BUS_BITS-1:0]  readdata;
   logic [BUS_BITS-1:0]  rd;
   word_t                io_in;
   word_t                io_out;
   word_t                bus_val;
   word_t                a_exp;
   word_t                b_exp;
   word_t                pat;
   int                   mismatches;
   int                   check_count;

   // 20 MHz core clock.
   always #25 core_clk = ~core_clk;

   dual_rank_bus_shift_register #(.STEP_DEPTH(STEP_DEPTH)) dut_u
   (
      .core_clk(core_clk), .rst_n(rst_n), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .io_in(io_in),
      .io_out(io_out), .io_oe_n(io_oe_n), .serial_in(serial_in),
      .serial_out(serial_out)
   );

   pin_bus_model model_u
   (
      .core_clk(core_clk), .io_out(io_out), .io_oe_n(io_oe_n),
      .io_in(io_in), .bus_en(bus_en), .bus_val(bus_val),
      .up_bit(up_bit), .serial_in(serial_in)
   );

   // Word comparison.
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   // Single-bit comparison.
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t: bit %b expected %b", $time, got, exp);
      end
   endtask

   // Waits for waitrequest low; only the watchdog ends a stuck wait.
   task automatic wait_ack();
      do
         @(posedge core_clk);
      while (waitrequest !== 1'b0);
   endtask

   // The trailing edge keeps a following request from colliding.
   task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      wait_ack();
      write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      wait_ack();
      d = readdata;
      read <= 1'b0;
      @(posedge core_clk);
   endtask

   // One queued device edge; the gap lets pin levels pass the synchroniser.
   task automatic do_step(input logic [5:0] c);
      bus_write(CTRL_ADDR, {26'h0, c});
      @(posedge core_clk);
      bus_write(STEP_ADDR, 32'h0);
      repeat (2) @(posedge core_clk);
   endtask

   task automatic chk_stat(input logic full_e, input logic empty_e);
      bus_read(STAT_ADDR, rd);
      chk32(rd, {13'h0, full_e, empty_e, b_exp[7], b_exp, a_exp});
      chk1(serial_out, b_exp[7]);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog far beyond the few hundred cycles the sequence needs.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      end_of_test();
   end

   // Main sequence.
   initial
   begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      bus_en = 1'b0;
      bus_val = 8'h00;
      up_bit = 1'b0;
      a_exp = 8'h00;
      b_exp = 8'h00;
      pat = 8'h5A;
      mismatches = 0;
      check_count = 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk_stat(1'b0, 1'b1);
      bus_en <= 1'b1;
      bus_val <= 8'hC3;
      do_step(6'h3E);
      a_exp = 8'hC3;
      chk1(io_oe_n, 1'b1);
      chk_stat(1'b0, 1'b1);
      // Load and transfer down in one edge while the other driver holds the pins.
      bus_val <= 8'h81;
      do_step(6'h36);
      b_exp = a_exp;
      a_exp = 8'h81;
      chk1(io_oe_n, 1'b1);
      chk_stat(1'b0, 1'b1);
      bus_en <= 1'b0;
      do_step(6'h37);
      b_exp = a_exp;
      chk_stat(1'b0, 1'b1);
      bus_en <= 1'b1;
      bus_val <= 8'h05;
      do_step(6'h3A);
      a_exp = 8'h05 | b_exp;
      chk_stat(1'b0, 1'b1);
      do_step(6'h33);
      {a_exp, b_exp} = {b_exp, a_exp};
      chk_stat(1'b0, 1'b1);
      chk32({24'h0, io_out}, {24'h0, a_exp});
      bus_val <= 8'hFF;
      do_step(6'h3C);
      chk1(io_oe_n, 1'b0);
      chk_stat(1'b0, 1'b1);
      bus_en <= 1'b0;
      do_step(6'h3B);
      a_exp = b_exp;
      chk_stat(1'b0, 1'b1);
      do_step(6'h3F);
      chk_stat(1'b0, 1'b1);
      // Shift a pattern in, most significant bit first.
      for (int i = 0; i < 8; i++)
      begin
         up_bit <= pat[7-i];
         do_step(6'h2F);
         b_exp = {b_exp[6:0], pat[7-i]};
         chk1(serial_out, b_exp[7]);
      end
      chk_stat(1'b0, 1'b1);
      // Stall the queue, fill it with shifts, then let it drain.
      up_bit <= 1'b0;
      bus_write(CTRL_ADDR, 32'h0F);
      for (int i = 0; i < STEP_DEPTH; i++)
         bus_write(STEP_ADDR, 32'h0);
      repeat (4) @(posedge core_clk);
      chk_stat(1'b1, 1'b0);
      bus_write(CTRL_ADDR, 32'h3F);
      repeat (12) @(posedge core_clk);
      b_exp = 8'h00;
      chk_stat(1'b0, 1'b1);
      bus_write(4'hC, 32'hFFFFFFFF);
      bus_read(4'hC, rd);
      chk32(rd, 32'h0);
      chk_stat(1'b0, 1'b1);
      // Second reset in mid-run.
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      a_exp = 8'h00;
      chk_stat(1'b0, 1'b1);
      chk1(io_oe_n, 1'b0);
      end_of_test();
   end
endmodule

`default_nettype wire
